/* File: common/sppc_pkg.sv */
// package: register map, field layout and types of the pulse counter
package sppc_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_CMD     = 8'h04;
  localparam logic [7:0] ADDR_PRESET  = 8'h08;
  localparam logic [7:0] ADDR_MODULO  = 8'h0c;
  localparam logic [7:0] ADDR_COMPARE = 8'h10;
  localparam logic [7:0] ADDR_REFLEX  = 8'h14;
  localparam logic [7:0] ADDR_STATUS  = 8'h18;
  localparam logic [7:0] ADDR_COUNT   = 8'h1c;
  localparam logic [7:0] ADDR_CAPTURE = 8'h20;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_MODE_BIT      = 0;
  localparam int CTRL_EN_USE_BIT    = 1;
  localparam int CTRL_LOAD_USE_BIT  = 2;
  localparam int CTRL_CAP_USE_BIT   = 3;
  localparam int CMD_FORCE_EN_BIT   = 7;
  localparam int CMD_FORCE_LOAD_BIT = 8;
  localparam int CMD_ACK_WRAP_BIT   = 9;
  localparam int CMD_ACK_LOAD_BIT   = 11;
  localparam int STAT_RUN_BIT       = 0;
  localparam int STAT_WRAP_BIT      = 2;
  localparam int STAT_LOADF_BIT     = 3;
  localparam int REFLEX_SEL_W       = 2;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
  localparam logic [31:0] CMD_RESET     = 32'h0000_0000;
  localparam logic [31:0] PRESET_RESET  = 32'h0000_0000;
  localparam logic [31:0] MODULO_RESET  = 32'h0000_0000;
  localparam logic [31:0] COMPARE_RESET = 32'h0000_0000;
  localparam logic [31:0] REFLEX_RESET  = 32'h0000_0000;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ           = 40_000_000;
  localparam int MAX_PULSE_HZ     = 250_000;
  localparam int REFLEX_MAX_US    = 20;
  localparam int MIN_PULSE_CYCLES = CLK_HZ / MAX_PULSE_HZ;
  localparam int REFLEX_MAX_CYCLES =
    REFLEX_MAX_US * (CLK_HZ / 1_000_000);

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    SUB_ONE_SHOT = 2'b00,
    SUB_MODULO   = 2'b01
  } sppc_mode_type;

  typedef enum logic [1:0] {
    REFLEX_OFF   = 2'b00,
    REFLEX_STOP  = 2'b01,
    REFLEX_WRAP  = 2'b10,
    REFLEX_MATCH = 2'b11
  } sppc_reflex_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } sppc_state_type;

  typedef struct packed {
    logic pulse;
    logic enable;
    logic load;
    logic capture;
  } sppc_pins_type;

endpackage : sppc_pkg

/* File: verilog/sppc_counter.sv */
// single phase pulse counter with axi4-lite register slave
//
// Summary of operation
// - running count kept in 32-bit register
// - capture edge copies count into capture register
// - enable, load, capture optionally from pins
// - up to four reflex outputs from comparisons
// - one count step per pulse, 250 kHz
// - reflex output follows trigger within 20 us
// - two sub modes: countdown and wrap
// - countdown load edge loads preset, activates
// - enabled countdown decrements per pulse to zero
// - at zero clear active, ignore pulses
// - load edge after stop reloads and resumes
// - stop reflex true while countdown count is zero
// - countdown disabled keeps count, ignores pulses
// - load edge overrides count in either mode
// - wrap mode load edge clears, activates
// - wrap mode enabled increments per pulse
// - limit minus one wraps to zero, flags
// - wrap flag held until acknowledge command
// - wrap mode disabled holds count
// - status bit 0 shows active, follows enable
// - command bit 8 rise acts as load
// - command bit 7 forces enable true
`timescale 1ns/1ps
`default_nettype none

module sppc_counter
  import sppc_pkg::*;
#(
  parameter int NUM_REFLEX = 4,
  parameter int CNT_W      = 32
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire sppc_pins_type         field_pins,
  output logic [NUM_REFLEX-1:0]      reflex_out
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [31:0]       ctrl;
  logic [31:0]       cmd;
  logic [31:0]       cmd_prev;
  logic [CNT_W-1:0]  preset;
  logic [CNT_W-1:0]  modulo;
  logic [CNT_W-1:0]  compare;
  logic [31:0]       reflex_cfg;
  logic [CNT_W-1:0]  count;
  logic [CNT_W-1:0]  capture;
  logic              wrap_flag;
  logic              load_flag;
  sppc_state_type    state;
  sppc_pins_type     sync_a;
  sppc_pins_type     sync_b;
  sppc_pins_type     sync_c;
  sppc_pins_type     rise;
  logic              enable_cond;
  logic              load_edge;
  logic              capture_edge;
  logic              count_pulse;
  logic              wrap_ack;
  logic              load_ack;
  logic              mode_wrap;
  logic              at_limit;
  logic [31:0]       status;

  logic              aw_full;
  logic              w_full;
  logic [7:0]        aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              wr_do;
  logic              wr_hit;
  logic [31:0]       rd_mux;
  logic              rd_hit;

  // ----------------------------------------------------------------
  // byte-lane merge
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  strb
  );
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction : merge

  // ----------------------------------------------------------------
  // axi write channels
  // ----------------------------------------------------------------
  assign s_axi_awready = !aw_full && !s_axi_bvalid;
  assign s_axi_wready  = !w_full && !s_axi_bvalid;
  assign wr_do         = aw_full && w_full && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      aw_addr <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_do) begin
      aw_full <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_do) begin
      w_full <= 1'b0;
    end
  end

  always_comb begin
    case (aw_addr)
      ADDR_CTRL, ADDR_CMD, ADDR_PRESET, ADDR_MODULO,
      ADDR_COMPARE, ADDR_REFLEX: wr_hit = 1'b1;
      default:                   wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_do) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // writable registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl       <= CTRL_RESET;
      cmd        <= CMD_RESET;
      preset     <= PRESET_RESET[CNT_W-1:0];
      modulo     <= MODULO_RESET[CNT_W-1:0];
      compare    <= COMPARE_RESET[CNT_W-1:0];
      reflex_cfg <= REFLEX_RESET;
    end else if (wr_do) begin
      case (aw_addr)
        ADDR_CTRL:    ctrl       <= merge(ctrl, w_data, w_strb);
        ADDR_CMD:     cmd        <= merge(cmd, w_data, w_strb);
        ADDR_PRESET:  preset     <= merge(preset, w_data, w_strb);
        ADDR_MODULO:  modulo     <= merge(modulo, w_data, w_strb);
        ADDR_COMPARE: compare    <= merge(compare, w_data, w_strb);
        ADDR_REFLEX:  reflex_cfg <= merge(reflex_cfg, w_data, w_strb);
        default:      ;
      endcase
    end
  end

  // command bits are levels; edges seen against last cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_prev <= CMD_RESET;
    end else begin
      cmd_prev <= cmd;
    end
  end

  // ----------------------------------------------------------------
  // axi read channel
  // ----------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      ADDR_CTRL:    rd_mux = ctrl;
      ADDR_CMD:     rd_mux = cmd;
      ADDR_PRESET:  rd_mux = preset;
      ADDR_MODULO:  rd_mux = modulo;
      ADDR_COMPARE: rd_mux = compare;
      ADDR_REFLEX:  rd_mux = reflex_cfg;
      ADDR_STATUS:  rd_mux = status;
      ADDR_COUNT:   rd_mux = count;
      ADDR_CAPTURE: rd_mux = capture;
      default: begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // input synchronisers and edge detect
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_a <= '0;
      sync_b <= '0;
      sync_c <= '0;
    end else begin
      sync_a <= field_pins;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  assign rise = sync_b & ~sync_c;

  // ----------------------------------------------------------------
  // condition sources
  // ----------------------------------------------------------------
  assign mode_wrap = ctrl[CTRL_MODE_BIT];

  assign enable_cond = cmd[CMD_FORCE_EN_BIT]
    || (ctrl[CTRL_EN_USE_BIT] && sync_b.enable);

  assign load_edge =
    (cmd[CMD_FORCE_LOAD_BIT] && !cmd_prev[CMD_FORCE_LOAD_BIT])
    || (ctrl[CTRL_LOAD_USE_BIT] && rise.load);

  assign capture_edge = ctrl[CTRL_CAP_USE_BIT] && rise.capture;

  assign wrap_ack =
    cmd[CMD_ACK_WRAP_BIT] && !cmd_prev[CMD_ACK_WRAP_BIT];
  assign load_ack =
    cmd[CMD_ACK_LOAD_BIT] && !cmd_prev[CMD_ACK_LOAD_BIT];

  // a pulse counts only while enabled and active
  assign count_pulse = rise.pulse && enable_cond
    && (state == ST_RUN) && !load_edge;

  assign at_limit = (count == modulo - CNT_W'(1));

  // ----------------------------------------------------------------
  // activity state
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (load_edge) begin
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (load_edge) begin
            state <= ST_RUN;
          end else if (count_pulse && !mode_wrap
                       && count == CNT_W'(1)) begin
            state <= ST_IDLE;
          end else if (!mode_wrap && count == '0) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // count register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= '0;
    end else if (load_edge) begin
      count <= mode_wrap ? '0 : preset;
    end else if (count_pulse) begin
      if (!mode_wrap) begin
        count <= count - CNT_W'(1);
      end else if (at_limit) begin
        count <= '0;
      end else begin
        count <= count + CNT_W'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // capture register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      capture <= '0;
    end else if (capture_edge) begin
      capture <= count;
    end
  end

  // ----------------------------------------------------------------
  // sticky flags, set wins over acknowledge
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wrap_flag <= 1'b0;
    end else if (count_pulse && mode_wrap && at_limit) begin
      wrap_flag <= 1'b1;
    end else if (wrap_ack) begin
      wrap_flag <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      load_flag <= 1'b0;
    end else if (load_edge) begin
      load_flag <= 1'b1;
    end else if (load_ack) begin
      load_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // status word
  // ----------------------------------------------------------------
  always_comb begin
    status = 32'h0000_0000;
    status[STAT_RUN_BIT]   = enable_cond && (state == ST_RUN);
    status[STAT_WRAP_BIT]  = wrap_flag;
    status[STAT_LOADF_BIT] = load_flag;
  end

  // ----------------------------------------------------------------
  // reflex outputs, one cycle after the trigger
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NUM_REFLEX; g++) begin : g_reflex
    sppc_reflex_type sel;
    assign sel = sppc_reflex_type'(
      reflex_cfg[REFLEX_SEL_W*g +: REFLEX_SEL_W]);
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        reflex_out[g] <= 1'b0;
      end else begin
        case (sel)
          REFLEX_STOP:  reflex_out[g] <= !mode_wrap
                                         && count == '0;
          REFLEX_WRAP:  reflex_out[g] <= wrap_flag;
          REFLEX_MATCH: reflex_out[g] <= count == compare;
          default:      reflex_out[g] <= 1'b0;
        endcase
      end
    end
  end

endmodule : sppc_counter

`default_nettype wire

/* File: testbench/sppc_chk.sv */
// checker: bus answer and reflex output assertions
`timescale 1ns/1ps
`default_nettype none
module sppc_chk
  import sppc_pkg::*;
#(
  parameter int NUM_REFLEX = 4
) (
  input wire logic                  aclk,
  input wire logic                  aresetn,
  input wire logic [7:0]            s_axi_awaddr,
  input wire logic                  s_axi_awvalid,
  input wire logic                  s_axi_awready,
  input wire logic [31:0]           s_axi_wdata,
  input wire logic [3:0]            s_axi_wstrb,
  input wire logic                  s_axi_wvalid,
  input wire logic                  s_axi_wready,
  input wire logic [1:0]            s_axi_bresp,
  input wire logic                  s_axi_bvalid,
  input wire logic                  s_axi_bready,
  input wire logic [7:0]            s_axi_araddr,
  input wire logic                  s_axi_arvalid,
  input wire logic                  s_axi_arready,
  input wire logic [31:0]           s_axi_rdata,
  input wire logic [1:0]            s_axi_rresp,
  input wire logic                  s_axi_rvalid,
  input wire logic                  s_axi_rready,
  input wire sppc_pins_type         field_pins,
  input wire logic [NUM_REFLEX-1:0] reflex_out
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sppc_pins_type pins_q;
  logic [3:0]    quiet;

  // cycles since the last pin change or write answer
  always_ff @(posedge aclk) begin
    pins_q <= field_pins;
    if (!aresetn || field_pins != pins_q || s_axi_bvalid)
      quiet <= 4'h0;
    else if (quiet != 4'hf)
      quiet <= quiet + 4'h1;
  end

  property p_rst_idle;
    disable iff (1'b0)
    !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && reflex_out == '0;
  endproperty
  // answer one cycle after both halves are held; only rw words accept
  property p_wr_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |->
      ##2 s_axi_bvalid && s_axi_bresp ==
      (($past(s_axi_awaddr, 2) > ADDR_REFLEX
      || $past(s_axi_awaddr[1:0], 2) != 2'b00) ? RESP_SLVERR : RESP_OKAY);
  endproperty
  property p_rd_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rresp ==
      (($past(s_axi_araddr) > ADDR_CAPTURE
      || $past(s_axi_araddr[1:0]) != 2'b00) ? RESP_SLVERR : RESP_OKAY);
  endproperty
  property p_b_drop;
    s_axi_bvalid && s_axi_bready |=>
      !s_axi_bvalid && s_axi_awready && s_axi_wready;
  endproperty
  property p_r_drop;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready;
  endproperty
  property p_b_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  property p_r_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  property p_rd_unmapped;
    s_axi_arvalid && s_axi_arready && s_axi_araddr > ADDR_CAPTURE |=>
      s_axi_rdata == 32'h0;
  endproperty
  property p_reflex_quiet;
    quiet >= 4'h8 |-> $stable(reflex_out);
  endproperty

  a_rst_idle: assert property (p_rst_idle) else $error("busy after reset");
  a_wr_answer: assert property (p_wr_answer) else $error("bad write answer");
  a_rd_answer: assert property (p_rd_answer) else $error("bad read answer");
  a_b_drop: assert property (p_b_drop) else $error("bvalid stuck");
  a_r_drop: assert property (p_r_drop) else $error("rvalid stuck");
  a_b_block: assert property (p_b_block) else $error("write taken early");
  a_r_block: assert property (p_r_block) else $error("read taken early");
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("stray data");
  a_reflex_quiet: assert property (p_reflex_quiet)
    else $error("reflex moved with no cause");

  c_cmd: cover property (s_axi_wvalid && s_axi_awaddr == ADDR_CMD);
  c_reflex: cover property ($rose(reflex_out[0]));
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule : sppc_chk

bind sppc_counter sppc_chk #(.NUM_REFLEX(NUM_REFLEX)) chk_u (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .field_pins(field_pins), .reflex_out(reflex_out)
);
`default_nettype wire

/* File: testbench/sppc_field.sv */
// partner: field pulse source and level inputs
`timescale 1ns/1ps
`default_nettype none
module sppc_field
  import sppc_pkg::*;
(
  input  wire logic    aclk,
  input  wire logic    start,
  input  wire logic [7:0] n,
  input  wire logic    en,
  input  wire logic    ld,
  input  wire logic    cp,
  output logic         busy,
  output sppc_pins_type pins
);
  logic [7:0] left;
  logic [2:0] ph;

  initial begin
    left = 8'h00;
    ph = 3'h0;
    pins = '0;
  end

  assign busy = left != 8'h00;

  // five cycles high, three low: far over the top pulse rate
  always @(posedge aclk) begin
    pins.enable <= en;
    pins.load <= ld;
    pins.capture <= cp;
    pins.pulse <= start || (busy && !ph[2]) || (busy && ph == 3'h4);
    if (start) begin
      left <= n;
      ph <= 3'h0;
    end else if (busy) begin
      ph <= ph + 3'h1;
      if (ph == 3'h7)
        left <= left - 8'h01;
    end
  end
endmodule : sppc_field
`default_nettype wire

/* File: testbench/tb.sv */
// testbench: countdown and wrap scenarios over the register bus
`timescale 1ns/1ps
`default_nettype none
module tb
  import sppc_pkg::*;
;
  logic          aclk, aresetn, awvalid, awready, wvalid, wready;
  logic          bvalid, bready, arvalid, arready, rvalid, rready;
  logic          start, busy, en, ld, cp;
  logic [7:0]    awaddr, araddr, n;
  logic [7:0]    regs [9];
  logic [31:0]   wdata, rdata;
  logic [1:0]    bresp, rresp;
  logic [3:0]    reflex;
  sppc_pins_type pins;
  int            err_count, checked, cycles;

  sppc_counter dut_u (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .field_pins(pins), .reflex_out(reflex)
  );
  sppc_field field_u (
    .aclk(aclk), .start(start), .n(n), .en(en), .ld(ld), .cp(cp),
    .busy(busy), .pins(pins)
  );

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic final_report;
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk

  function automatic logic [31:0] resp_of(input logic [7:0] a);
    return {30'h0, (a > ADDR_CAPTURE) ? RESP_SLVERR : RESP_OKAY};
  endfunction : resp_of

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ad;
    logic dd;
    @(posedge aclk);
    ad = 1'b0;
    dd = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        dd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
    chk("bresp", resp_of(a), {30'h0, bresp});
  endtask : wr

  task automatic rc(input string nm, input logic [7:0] a,
                    input logic [31:0] e);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
    chk(nm, e, rdata);
    chk("rresp", resp_of(a), {30'h0, rresp});
  endtask : rc

  task automatic pin(input logic e, input logic l, input logic c);
    @(posedge aclk);
    en <= e;
    ld <= l;
    cp <= c;
    repeat (8) @(posedge aclk);
  endtask : pin

  task automatic pul(input logic [7:0] k, input logic l);
    @(posedge aclk);
    n <= k;
    start <= 1'b1;
    if (l)
      ld <= 1'b1;
    @(posedge aclk);
    start <= 1'b0;
    @(posedge aclk);
    while (busy) @(posedge aclk);
    repeat (8) @(posedge aclk);
  endtask : pul

  always @(posedge aclk) begin
    cycles++;
    if (cycles == 6000) begin
      err_count++;
      final_report();
    end
  end

  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {start, en, ld, cp} = 4'h0;
    {awaddr, araddr, n} = 24'h0;
    wdata = 32'h0;
    err_count = 0;
    checked = 0;
    cycles = 0;
    regs = '{ADDR_CTRL, ADDR_CMD, ADDR_PRESET, ADDR_MODULO, ADDR_COMPARE,
             ADDR_REFLEX, ADDR_STATUS, ADDR_COUNT, ADDR_CAPTURE};
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (regs[i]) rc("reset", regs[i], 32'h0);
    rc("unmapped", 8'h24, 32'h0);
    wr(8'h24, 32'h5);
    wr(ADDR_CTRL, 32'ha);
    wr(ADDR_REFLEX, 32'h1);
    wr(ADDR_PRESET, 32'h3);
    pin(1'b1, 1'b0, 1'b0);
    wr(ADDR_CMD, 32'h100);
    rc("count", ADDR_COUNT, 32'h3);
    rc("status", ADDR_STATUS, 32'h9);
    wr(ADDR_CMD, 32'h800);
    pul(8'd2, 1'b0);
    rc("count", ADDR_COUNT, 32'h1);
    pin(1'b0, 1'b0, 1'b0);
    pul(8'd2, 1'b0);
    rc("count", ADDR_COUNT, 32'h1);
    rc("status", ADDR_STATUS, 32'h0);
    pin(1'b1, 1'b0, 1'b1);
    rc("capture", ADDR_CAPTURE, 32'h1);
    pul(8'd3, 1'b0);
    rc("count", ADDR_COUNT, 32'h0);
    rc("status", ADDR_STATUS, 32'h0);
    chk("reflex", 32'h1, {28'h0, reflex});
    wr(ADDR_CTRL, 32'he);
    pin(1'b1, 1'b1, 1'b1);
    rc("count", ADDR_COUNT, 32'h3);
    rc("status", ADDR_STATUS, 32'h9);
    chk("reflex", 32'h0, {28'h0, reflex});
    pin(1'b1, 1'b0, 1'b1);
    wr(ADDR_PRESET, 32'h5);
    pul(8'd1, 1'b1);
    rc("count", ADDR_COUNT, 32'h5);
    pin(1'b0, 1'b0, 1'b0);
    wr(ADDR_CMD, 32'h80);
    pul(8'd2, 1'b0);
    rc("count", ADDR_COUNT, 32'h3);
    wr(ADDR_CMD, 32'h0);
    wr(ADDR_CTRL, 32'h3);
    wr(ADDR_MODULO, 32'h3);
    wr(ADDR_REFLEX, 32'h80);
    pin(1'b1, 1'b0, 1'b0);
    wr(ADDR_CMD, 32'h100);
    rc("count", ADDR_COUNT, 32'h0);
    pul(8'd2, 1'b0);
    rc("count", ADDR_COUNT, 32'h2);
    pul(8'd1, 1'b0);
    rc("count", ADDR_COUNT, 32'h0);
    rc("status", ADDR_STATUS, 32'hd);
    chk("reflex", 32'h8, {28'h0, reflex});
    pul(8'd1, 1'b0);
    rc("status", ADDR_STATUS, 32'hd);
    wr(ADDR_CMD, 32'h200);
    rc("status", ADDR_STATUS, 32'h9);
    pin(1'b0, 1'b0, 1'b0);
    pul(8'd2, 1'b0);
    rc("count", ADDR_COUNT, 32'h1);
    pin(1'b1, 1'b0, 1'b0);
    pul(8'd1, 1'b0);
    rc("count", ADDR_COUNT, 32'h2);
    wr(ADDR_COMPARE, 32'h2);
    wr(ADDR_REFLEX, 32'hc0);
    rc("compare", ADDR_COMPARE, 32'h2);
    chk("reflex", 32'h8, {28'h0, reflex});
    pul(8'd1, 1'b0);
    chk("reflex", 32'h0, {28'h0, reflex});
    final_report();
  end
endmodule : tb
`default_nettype wire
